// *** rtl/wdg_defines.svh ***
// Register numbers, field positions, codes and timing constants of the process-data watchdog
`ifndef WDG_DEFINES_SVH
`define WDG_DEFINES_SVH

// Register numbers as seen by the remote client
`define WDG_REG_TMO 16'h07d0
`define WDG_REG_MODE 16'h07d2
`define WDG_REG_REASON 16'h07d4
`define WDG_REG_CMD 16'h07d6
`define WDG_REG_STATUS 16'h1f3c
`define WDG_REG_PD_OUT 16'h2328

// Reset values
`define WDG_TMO_RST 16'h0000
`define WDG_MODE_RST 2'h0
`define WDG_REASON_RST 16'h0000
`define WDG_PD_RST 16'h0000

// Legal nonzero timeout window in ms
`define WDG_TMO_MIN_MS 16'h00c8
`define WDG_TMO_MAX_MS 16'hfde8

// Highest legal fault response code
`define WDG_MODE_MAX 16'h0002

// Failure reason codes
`define WDG_RSN_LINK 16'h0007
`define WDG_RSN_HOST 16'h0008
`define WDG_RSN_USER 16'h0009
`define WDG_RSN_ABORT 16'h000a
`define WDG_RSN_INIT 16'h000b
`define WDG_RSN_WDOG 16'h000c
`define WDG_RSN_CONN 16'h000d

// Command bit positions
`define WDG_CMD_SET_BIT 4
`define WDG_CMD_ACK_BIT 5
`define WDG_CMD_CLRW_BIT 7

// Status bit positions
`define WDG_STAT_ERR_BIT 0
`define WDG_STAT_FAIL_BIT 1

// Timing: one millisecond at the 125 MHz reference clock
`define WDG_CLK_PERIOD_NS 8
`define WDG_MS_NS 1000000
`define WDG_MS_CYCLES (`WDG_MS_NS / `WDG_CLK_PERIOD_NS)
`define WDG_TICK_W 17

`endif

// *** rtl/wdg_pkg.sv ***
// Types shared by the process-data watchdog modules
package wdg_pkg;

	typedef enum logic [3:0] {
		WD_OFF = 4'b0001,
		WD_WAIT = 4'b0010,
		WD_RUN = 4'b0100,
		WD_FAIL = 4'b1000
	} wd_state_t;

	typedef enum logic [1:0] {
		FM_LOW = 2'h0,
		FM_HIGH = 2'h1,
		FM_HOLD = 2'h2
	} fault_mode_t;

	typedef struct packed {
		wd_state_t state;
		logic [15:0] tmo;
		fault_mode_t mode;
		logic [15:0] reason;
		logic [15:0] pd;
		logic [15:0] dout;
		logic [15:0] ms_cnt;
		logic net_fail;
		logic io_warn;
		logic error;
		logic [15:0] rdata;
		logic ack;
		logic exc;
	} wdg_state_t;

	typedef struct packed {
		logic [16:0] cnt;
		logic tick;
	} tick_state_t;

endpackage

// *** rtl/ms_tick.sv ***
// Millisecond tick generator for the watchdog count
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.svh"

module ms_tick #(
	parameter int unsigned CYCLES = `WDG_MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic restart,
	output logic tick_q
);
	wdg_pkg::tick_state_t s_q;
	wdg_pkg::tick_state_t s_d;

	// Prescaler; restart realigns the millisecond grid to the trigger
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (restart) begin
			s_d.cnt = '0;
		end else if (s_q.cnt == `WDG_TICK_W'(CYCLES - 1)) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + `WDG_TICK_W'(1);
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign tick_q = s_q.tick;

endmodule // ms_tick
`default_nettype wire

// *** rtl/process_data_watchdog_regs.sv ***
// Output process-data watchdog with its fault response, reason, command and status registers
// Summary of operation
// - Nonzero timeout must be 200 to 65000 ms; other nonzero values are refused.
// - Timeout zero keeps the watchdog off; it never declares an expiry.
// - On net failure outputs go all low, all high, or hold, per mode.
// - Fault response mode is writable by the client and by management.
// - The reason for the latest net failure is readable in its register.
// - Reason codes: 0c expiry, 0d connection, 09 user, 07 link, 08 host, 0a, 0b.
// - Command writes carry exactly one bit; several bits raise an exception.
// - The command register is write-only; reading it raises an exception.
// - Command 0010 forces failure, 0020 acknowledges it, 0080 clears I/O warning.
// - Status bit 0 is set while any error, diagnostic bit included, exists.
// - Status bit 1 is set while net failure and substitute outputs are active.
// - First output write starts the count; each further write restarts it.
// - Reads never touch the watchdog count.
// - Expiry applies substitute outputs and sets the net failure bit.
// - In automatic mode the next output write clears failure and restarts.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.svh"

module process_data_watchdog_regs #(
	parameter int unsigned MS_CYCLES = `WDG_MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata_q,
	output logic reg_ack_q,
	output logic reg_exc_q,
	input wire logic mgmt_mode_wr,
	input wire logic [1:0] mgmt_mode,
	input wire logic mgmt_ack,
	input wire logic ack_auto,
	input wire logic [15:0] diag_bits,
	input wire logic io_warn_evt,
	input wire logic conn_tmo_evt,
	input wire logic internal_link_tmo_evt,
	input wire logic host_tmo_evt,
	input wire logic conn_abort_evt,
	input wire logic init_err_evt,
	output logic [15:0] dout_q,
	output logic net_fail_q,
	output logic error_q,
	output logic io_warn_q
);
	wdg_pkg::wdg_state_t s_q;
	wdg_pkg::wdg_state_t s_d;
	logic tick;
	logic wr_pd;
	logic cmd_ok;
	logic tmo_bad;
	logic wd_exp;
	logic fail_clr;
	logic fail_set;
	logic [15:0] set_code;

	// Request decode; a write wins over a read in the same cycle
	assign wr_pd = ce && reg_wr && reg_addr == `WDG_REG_PD_OUT;
	assign cmd_ok = reg_wr && reg_addr == `WDG_REG_CMD && $onehot(reg_wdata);
	assign tmo_bad = reg_wdata != 16'h0000 && (reg_wdata < `WDG_TMO_MIN_MS || reg_wdata > `WDG_TMO_MAX_MS);

	// Prescaler restarts with each trigger so the first period is a full one
	ms_tick #(
		.CYCLES(MS_CYCLES)
	) u_tick (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ce(ce),
		.restart(wr_pd),
		.tick_q(tick)
	);

	// Next-state logic: register access, watchdog, failure latch, outputs
	always_comb begin
		s_d = s_q;
		wd_exp = 1'b0;
		fail_clr = 1'b0;
		fail_set = 1'b0;
		set_code = `WDG_REASON_RST;
		s_d.ack = 1'b0;
		s_d.exc = 1'b0;
		if (reg_wr || reg_rd) begin
			s_d.ack = 1'b1;
			s_d.rdata = 16'h0000;
			case (reg_addr)
				`WDG_REG_TMO: begin
					if (!reg_wr) begin
						s_d.rdata = s_q.tmo;
					end else if (tmo_bad) begin
						s_d.exc = 1'b1;
					end else begin
						s_d.tmo = reg_wdata;
					end
				end
				`WDG_REG_MODE: begin
					if (!reg_wr) begin
						s_d.rdata = {14'h0000, s_q.mode};
					end else if (reg_wdata > `WDG_MODE_MAX) begin
						s_d.exc = 1'b1;
					end else begin
						s_d.mode = wdg_pkg::fault_mode_t'(reg_wdata[1:0]);
					end
				end
				`WDG_REG_REASON: begin
					s_d.exc = reg_wr;
					s_d.rdata = reg_wr ? 16'h0000 : s_q.reason;
				end
				`WDG_REG_CMD: begin
					s_d.exc = !cmd_ok;
				end
				`WDG_REG_STATUS: begin
					s_d.exc = reg_wr;
					if (!reg_wr) begin
						s_d.rdata[`WDG_STAT_ERR_BIT] = s_q.error;
						s_d.rdata[`WDG_STAT_FAIL_BIT] = s_q.net_fail;
					end
				end
				`WDG_REG_PD_OUT: begin
					if (reg_wr) begin
						s_d.pd = reg_wdata;
					end else begin
						s_d.rdata = s_q.pd;
					end
				end
				default: begin
					s_d.exc = 1'b1;
				end
			endcase
		end
		// Management path is checked the same way; it lands after the client write
		if (mgmt_mode_wr && {14'h0000, mgmt_mode} <= `WDG_MODE_MAX) begin
			s_d.mode = wdg_pkg::fault_mode_t'(mgmt_mode);
		end

		// Watchdog sequencing; reads reach none of this
		case (s_q.state)
			wdg_pkg::WD_OFF: begin
				if (s_d.tmo != 16'h0000) begin
					s_d.state = wdg_pkg::WD_WAIT;
				end
			end
			wdg_pkg::WD_WAIT: begin
				if (s_d.tmo == 16'h0000) begin
					s_d.state = wdg_pkg::WD_OFF;
				end else if (wr_pd) begin
					s_d.state = wdg_pkg::WD_RUN;
					s_d.ms_cnt = 16'h0000;
				end
			end
			wdg_pkg::WD_RUN: begin
				if (s_d.tmo == 16'h0000) begin
					s_d.state = wdg_pkg::WD_OFF;
				end else if (wr_pd) begin
					s_d.ms_cnt = 16'h0000;
				end else if (tick) begin
					if ({1'b0, s_q.ms_cnt} + 17'h00001 >= {1'b0, s_d.tmo}) begin
						wd_exp = 1'b1;
					end else begin
						s_d.ms_cnt = s_q.ms_cnt + 16'h0001;
					end
				end
			end
			wdg_pkg::WD_FAIL: begin
				fail_clr = mgmt_ack || (cmd_ok && reg_wdata[`WDG_CMD_ACK_BIT]) || (ack_auto && wr_pd);
			end
			default: begin
				s_d.state = wdg_pkg::WD_OFF;
			end
		endcase
		if (fail_clr) begin
			s_d.state = s_d.tmo != 16'h0000 ? wdg_pkg::WD_RUN : wdg_pkg::WD_OFF;
			s_d.ms_cnt = 16'h0000;
		end

		// Failure causes in fixed priority; a set in the clearing cycle wins
		fail_set = 1'b1;
		if (cmd_ok && reg_wdata[`WDG_CMD_SET_BIT]) begin
			set_code = `WDG_RSN_USER;
		end else if (wd_exp) begin
			set_code = `WDG_RSN_WDOG;
		end else if (conn_tmo_evt) begin
			set_code = `WDG_RSN_CONN;
		end else if (internal_link_tmo_evt) begin
			set_code = `WDG_RSN_LINK;
		end else if (host_tmo_evt) begin
			set_code = `WDG_RSN_HOST;
		end else if (conn_abort_evt) begin
			set_code = `WDG_RSN_ABORT;
		end else if (init_err_evt) begin
			set_code = `WDG_RSN_INIT;
		end else begin
			fail_set = 1'b0;
		end
		if (fail_set) begin
			s_d.state = wdg_pkg::WD_FAIL;
			s_d.reason = set_code;
			s_d.ms_cnt = 16'h0000;
		end
		s_d.net_fail = s_d.state == wdg_pkg::WD_FAIL;

		// Latched I/O warning; a new warning beats the clear
		if (cmd_ok && reg_wdata[`WDG_CMD_CLRW_BIT]) begin
			s_d.io_warn = 1'b0;
		end
		if (io_warn_evt) begin
			s_d.io_warn = 1'b1;
		end
		s_d.error = (|diag_bits) || s_d.io_warn || s_d.net_fail;

		// Substitute values while failed; hold keeps what was last applied
		if (s_d.net_fail) begin
			case (s_d.mode)
				wdg_pkg::FM_LOW: s_d.dout = 16'h0000;
				wdg_pkg::FM_HIGH: s_d.dout = 16'hffff;
				wdg_pkg::FM_HOLD: s_d.dout = s_q.dout;
				default: s_d.dout = 16'h0000;
			endcase
		end else begin
			s_d.dout = s_d.pd;
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.state <= wdg_pkg::WD_OFF;
			s_q.tmo <= `WDG_TMO_RST;
			s_q.mode <= wdg_pkg::fault_mode_t'(`WDG_MODE_RST);
			s_q.reason <= `WDG_REASON_RST;
			s_q.pd <= `WDG_PD_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_q = s_q.rdata;
	assign reg_ack_q = s_q.ack;
	assign reg_exc_q = s_q.exc;
	assign dout_q = s_q.dout;
	assign net_fail_q = s_q.net_fail;
	assign error_q = s_q.error;
	assign io_warn_q = s_q.io_warn;

	// Checks on the register and watchdog behaviour
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	chk_tmo_range: assert property (ce && reg_wr && reg_addr == `WDG_REG_TMO && reg_wdata != 16'h0000 && reg_wdata < 16'h00c8 |=> reg_ack_q && reg_exc_q && $stable(s_q.tmo)) else $error("short timeout accepted");
	chk_zero_quiet: assert property (s_q.tmo == 16'h0000 |->
		!wd_exp && s_q.state != wdg_pkg::WD_RUN && s_q.state != wdg_pkg::WD_WAIT) else $error("watchdog active with zero timeout");
	chk_subst_out: assert property (s_q.net_fail && s_q.mode == wdg_pkg::FM_HIGH |-> dout_q == 16'hffff) else $error("high substitute missing");
	chk_subst_hold: assert property (ce && s_q.net_fail && s_d.net_fail && s_q.mode == wdg_pkg::FM_HOLD && s_d.mode == wdg_pkg::FM_HOLD |=> $stable(dout_q)) else $error("hold substitute moved");
	chk_mode_write: assert property (ce && reg_wr && reg_addr == `WDG_REG_MODE && reg_wdata <= 16'h0002 && !mgmt_mode_wr |=> s_q.mode == $past(reg_wdata[1:0])) else $error("mode write lost");
	chk_multi_cmd: assert property (ce && reg_wr && reg_addr == `WDG_REG_CMD && $countones(reg_wdata) > 1 |=> reg_ack_q && reg_exc_q) else $error("multi-bit command taken");
	chk_cmd_read: assert property (ce && reg_rd && !reg_wr && reg_addr == `WDG_REG_CMD |=> reg_exc_q && reg_rdata_q == 16'h0000) else $error("command register readable");
	chk_user_fail: assert property (ce && reg_wr && reg_addr == `WDG_REG_CMD && reg_wdata == 16'h0010 |=> net_fail_q && s_q.reason == 16'h0009) else $error("forced failure missing");
	chk_status_rd: assert property (ce && reg_rd && !reg_wr && reg_addr == `WDG_REG_STATUS |=> reg_rdata_q[1] == $past(net_fail_q) && reg_rdata_q[15:2] == 14'h0000) else $error("status word wrong");
	chk_err_bit: assert property ($past(ce) && $past(rstn) |->
		error_q == (net_fail_q || io_warn_q || (|$past(diag_bits)))) else $error("error bit wrong");
	chk_wd_expire: assert property (ce && wd_exp && !(cmd_ok && reg_wdata[`WDG_CMD_SET_BIT]) |=>
		net_fail_q && s_q.reason == 16'h000c) else $error("expiry not reported");
	chk_read_nochg: assert property (ce && reg_rd && !reg_wr && s_q.state == wdg_pkg::WD_RUN && !tick && s_d.tmo != 16'h0000 && !fail_set |=> $stable(s_q.ms_cnt) && s_q.state == wdg_pkg::WD_RUN) else $error("read moved count");
	chk_auto_clear: assert property (ce && net_fail_q && ack_auto && wr_pd && !fail_set |=> !net_fail_q ##0 (s_q.ms_cnt == 16'h0000)) else $error("auto acknowledge failed");

	cov_expiry: cover property (ce && wd_exp);
	cov_manual_ack: cover property (ce && net_fail_q && reg_wr && reg_addr == `WDG_REG_CMD && reg_wdata == 16'h0020 ##1 !net_fail_q);
	cov_auto_ack: cover property (ce && net_fail_q && ack_auto && wr_pd ##1 !net_fail_q);
	cov_hold_fail: cover property (net_fail_q && s_q.mode == wdg_pkg::FM_HOLD);

endmodule // process_data_watchdog_regs
`default_nettype wire

// *** tb/client_model.sv ***
// Remote client model issuing register accesses to the watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.svh"

module client_model (
	input wire logic ref_clk,
	input wire logic [15:0] reg_rdata_q,
	input wire logic reg_ack_q,
	input wire logic reg_exc_q,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_addr,
	output logic [15:0] reg_wdata
);
	logic [15:0] rd_q;
	logic exc_q;

	// Idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end

	// One word per access: single-cycle request, bounded wait for the answer
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		#1;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge ref_clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		while (!reg_ack_q && n < 4) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		rd_q = reg_rdata_q;
		exc_q = reg_ack_q ? reg_exc_q : 1'bx; // A lost answer never looks valid
		reg_addr = ~a; // Released lines do not keep stale values
		reg_wdata = ~d;
	endtask

	// Commands carry exactly one bit per access
	task automatic cmd(input int b);
		xfer(1'b1, `WDG_REG_CMD, 16'h0001 << b);
	endtask
endmodule // client_model
`default_nettype wire

// *** tb/process_data_watchdog_regs_tb.sv ***
// Self-checking bench for the process-data watchdog registers
`timescale 1ns/1ps
`default_nettype none
`include "wdg_defines.svh"

module process_data_watchdog_regs_tb;
	localparam int MSC = 10;
	localparam logic [15:0] RC [5] = '{16'h000b, 16'h000a, 16'h0008, 16'h0007, 16'h000d};
	localparam logic [15:0] TB [4] = '{16'h00c7, 16'h00c8, 16'hfde8, 16'hfde9};
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic ack_auto = 1'b0;
	logic ce = 1'b1;
	logic [7:0] ev = 8'h00;
	logic [1:0] mgmt_mode = 2'h0;
	logic [15:0] diag_bits = 16'h0000;
	logic [15:0] reg_rdata_q, reg_addr, reg_wdata, dout_q, v, t;
	logic reg_ack_q, reg_exc_q, reg_wr, reg_rd, net_fail_q, error_q, io_warn_q, x;
	logic [31:0] lf;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int t0;

	// Clock and cycle count
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;

	process_data_watchdog_regs #(.MS_CYCLES(MSC)) dut_u (.ref_clk, .rstn, .ce,
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q, .reg_ack_q, .reg_exc_q,
		.mgmt_mode_wr(ev[7]), .mgmt_mode, .mgmt_ack(ev[6]), .ack_auto, .diag_bits,
		.io_warn_evt(ev[5]), .conn_tmo_evt(ev[4]), .internal_link_tmo_evt(ev[3]),
		.host_tmo_evt(ev[2]), .conn_abort_evt(ev[1]), .init_err_evt(ev[0]),
		.dout_q, .net_fail_q, .error_q, .io_warn_q);

	client_model cl_u (.ref_clk, .reg_rdata_q, .reg_ack_q, .reg_exc_q,
		.reg_wr, .reg_rd, .reg_addr, .reg_wdata);

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic chkb(input string s, input logic e, input logic g);
		chk(s, {15'h0000, e}, {15'h0000, g});
	endtask

	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic xe);
		cl_u.xfer(w, a, d);
		chkb("exception", xe, cl_u.exc_q);
	endtask

	task automatic rdc(input logic [15:0] a, input logic [15:0] e);
		acc(1'b0, a, 16'h0000, 1'b0);
		chk("read data", e, cl_u.rd_q);
	endtask

	// Side inputs pulse for one cycle
	task automatic pulse(input int i);
		@(posedge ref_clk);
		#1;
		ev[i] = 1'b1;
		@(posedge ref_clk);
		#1;
		ev[i] = 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Hang guard, well beyond the expected run of about 6300 cycles
	initial begin
		repeat (40000) @(posedge ref_clk);
		n_fail++;
		summarize();
	end

	initial begin
		lf = 32'h00015aad;
		t = 16'h0000;
		repeat (20) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		// Reset state and refused places
		rdc(`WDG_REG_TMO, 16'h0000);
		rdc(`WDG_REG_STATUS, 16'h0000);
		acc(1'b0, `WDG_REG_CMD, 16'h0000, 1'b1);
		acc(1'b1, `WDG_REG_REASON, 16'h0009, 1'b1);
		acc(1'b1, 16'h0123, 16'h0001, 1'b1);
		// Timeout bounds first, then random words
		for (int i = 0; i < 24; i++) begin
			v = i < 4 ? TB[i] : lf[15:0];
			lf = nxt(lf);
			x = v != 0 && (v < `WDG_TMO_MIN_MS || v > `WDG_TMO_MAX_MS);
			t = x ? t : v;
			acc(1'b1, `WDG_REG_TMO, v, x);
			rdc(`WDG_REG_TMO, t);
		end
		acc(1'b1, `WDG_REG_TMO, 16'h0000, 1'b0);
		// Every response code under a forced failure; code 3 is refused, hold stays
		for (int m = 0; m < 4; m++) begin
			v = lf[15:0];
			lf = nxt(lf);
			acc(1'b1, `WDG_REG_MODE, 16'(m), m == 3);
			acc(1'b1, `WDG_REG_PD_OUT, v, 1'b0);
			acc(1'b1, `WDG_REG_CMD, 16'h0030, 1'b1);
			chkb("net fail", 1'b0, net_fail_q);
			cl_u.cmd(`WDG_CMD_SET_BIT);
			chkb("error", 1'b1, error_q);
			rdc(`WDG_REG_STATUS, 16'h0003);
			rdc(`WDG_REG_REASON, `WDG_RSN_USER);
			chk("dout", m == 1 ? 16'hffff : m == 0 ? 16'h0000 : v, dout_q);
			if (m[0]) pulse(6);
			else cl_u.cmd(`WDG_CMD_ACK_BIT);
			repeat (2) @(posedge ref_clk);
			#1;
			chkb("net fail", 1'b0, net_fail_q);
			chk("dout", v, dout_q);
		end
		mgmt_mode = 2'h1;
		pulse(7);
		rdc(`WDG_REG_MODE, 16'h0001);
		// Single reserved bit, warning latch and diagnostic bits
		acc(1'b1, `WDG_REG_CMD, 16'h0001, 1'b0);
		chkb("net fail", 1'b0, net_fail_q);
		pulse(5);
		chkb("io warn", 1'b1, io_warn_q);
		rdc(`WDG_REG_STATUS, 16'h0001);
		cl_u.cmd(`WDG_CMD_CLRW_BIT);
		chkb("io warn", 1'b0, io_warn_q);
		rdc(`WDG_REG_STATUS, 16'h0000);
		diag_bits = 16'h0400;
		rdc(`WDG_REG_STATUS, 16'h0001);
		chkb("error", 1'b1, error_q);
		diag_bits = 16'h0000;
		// Other failure causes and their codes
		for (int i = 0; i < 5; i++) begin
			pulse(i);
			rdc(`WDG_REG_REASON, RC[i]);
			pulse(6);
		end
		// Refreshed watchdog, then reads only until expiry
		acc(1'b1, `WDG_REG_TMO, `WDG_TMO_MIN_MS, 1'b0);
		acc(1'b1, `WDG_REG_PD_OUT, 16'h00a5, 1'b0);
		repeat (1500) @(posedge ref_clk);
		#1;
		chkb("net fail", 1'b0, net_fail_q);
		acc(1'b1, `WDG_REG_PD_OUT, 16'h005a, 1'b0);
		t0 = cyc;
		repeat (300) rdc(`WDG_REG_PD_OUT, 16'h005a);
		// Poll off the edge so the flag and the cycle count are settled
		while (!net_fail_q && cyc - t0 < 2100) begin
			@(posedge ref_clk);
			#1;
		end
		chkb("expiry time", 1'b1, cyc - t0 >= 200 * MSC - 4 && cyc - t0 <= 200 * MSC + 6);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("dout", 16'hffff, dout_q);
		rdc(`WDG_REG_REASON, `WDG_RSN_WDOG);
		// Automatic confirmation, then a stopped watchdog never expires
		ack_auto = 1'b1;
		acc(1'b1, `WDG_REG_PD_OUT, 16'h0f0f, 1'b0);
		acc(1'b1, `WDG_REG_TMO, 16'h0000, 1'b0);
		chkb("net fail", 1'b0, net_fail_q);
		chk("dout", 16'h0f0f, dout_q);
		repeat (2500) @(posedge ref_clk);
		#1;
		chkb("net fail", 1'b0, net_fail_q);
		// Clock enable low freezes the block; a cause raised then is lost
		ce = 1'b0;
		pulse(4);
		ce = 1'b1;
		chkb("net fail", 1'b0, net_fail_q);
		rdc(`WDG_REG_REASON, `WDG_RSN_WDOG);
		summarize();
	end
endmodule // process_data_watchdog_regs_tb
`default_nettype wire
